// ==== cpu_exception_classifier.sv ====
// Notes on behaviour
// - outside events async; irq precise maskable; reset and check imprecise
// - instruction-caused exceptions are precise
// - fp exceptions precise even in imprecise fp mode
// - soft or hard reset takes 00100; 00000 unused
// - data bus error, check pin or parity error take 00200
// - data fault 00300; cause bit 1 on total miss, else clear
// - cause bit 4 on page or block protection refusal
// - cause bit 5 for ext-control write-through or direct-store
// - cause bit 6 set for store, clear for load
// - cause bit 11 for ext-control access with enable clear
// - untranslatable fetch takes instruction fault 00400
// - direct-store fetch faults, sets saved status bit 3
// - fetch protection violation sets saved status bit 4
// - keys with page protection forbidding read refuse fetch
// - ext irq with enable bit one takes 00500
// - irq waits for completion or known restart address
`include "exc_classifier_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_exception_classifier (
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire logic              HSEL,
    input  wire logic [31:0]       HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output var  logic [31:0]       HRDATA,
    output var  logic              HREADYOUT,
    output var  logic              HRESP,
    input  wire logic              SOFT_RESET_IN,
    input  wire logic              HARD_RESET_IN,
    input  wire logic              TRANSFER_ERROR_ACK,
    input  wire logic              MACHINE_CHECK_IN,
    input  wire logic              EXT_IRQ_IN,
    input  wire logic              DATA_BUS_ACTIVE,
    input  wire logic              ADDR_PARITY_ERR,
    input  wire logic              DATA_PARITY_ERR,
    input  wire logic              DACC_CHECK,
    input  wire logic              DACC_MISS_PRI,
    input  wire logic              DACC_MISS_SEC,
    input  wire logic              DACC_MISS_BLK,
    input  wire logic              DACC_PROT_DENY,
    input  wire logic              DACC_EXT_CTRL,
    input  wire logic              DACC_WRITE_THRU,
    input  wire logic              DACC_DIRECT_STORE,
    input  wire logic              DACC_STORE,
    input  wire logic              IFETCH_CHECK,
    input  wire logic              IFETCH_PAGE_FAULT,
    input  wire logic              IFETCH_DIRECT_STORE,
    input  wire logic              IFETCH_SUPERVISOR_KEY,
    input  wire logic              IFETCH_USER_KEY,
    input  wire logic [1:0]        IFETCH_PAGE_PROTECT,
    input  wire logic              SYNC_EXC_REQ,
    input  wire logic              SYNC_EXC_FP,
    input  wire logic [`VEC_W-1:0] SYNC_EXC_OFFSET,
    input  wire logic              FP_IMPRECISE_MODE,
    input  wire logic              INSTR_COMPLETE,
    input  wire logic              INSTR_IN_FLIGHT,
    input  wire logic              RESTART_KNOWN,
    output var  logic              EXC_TAKEN,
    output var  logic [`VEC_W-1:0] EXC_OFFSET,
    output var  logic [31:0]       EXC_ENTRY_ADDR,
    output var  logic              EXC_ASYNC,
    output var  logic              EXC_PRECISE,
    output var  logic              EXC_MASKABLE,
    output var  logic              SUPERVISOR,
    output var  logic              FETCH_REFUSED,
    output var  logic              IRQ
);

    function automatic logic read_forbidden(input logic sup_key, input logic user_key,
                                            input logic pr, input logic [1:0] pp);
        return (pr ? user_key : sup_key) && (pp == 2'h0);
    endfunction : read_forbidden

    function automatic logic [`VEC_W-1:0] vec_of(input exc_classifier_pkg::exc_kind_t k,
                                                 input logic [`VEC_W-1:0] sync_off);
        unique case (k)
            exc_classifier_pkg::EXC_RESET:  return `VEC_SYS_RESET;
            exc_classifier_pkg::EXC_MCHECK: return `VEC_MCHECK;
            exc_classifier_pkg::EXC_DFAULT: return `VEC_DFAULT;
            exc_classifier_pkg::EXC_IFAULT: return `VEC_IFAULT;
            exc_classifier_pkg::EXC_EXT:    return `VEC_EXT_IRQ;
            exc_classifier_pkg::EXC_SYNC:   return sync_off;
            default:                        return `VEC_RESERVED;
        endcase
    endfunction : vec_of

    function automatic exc_classifier_pkg::exc_class_t class_of(
            input exc_classifier_pkg::exc_kind_t k);
        exc_classifier_pkg::exc_class_t c;
        unique case (k)
            exc_classifier_pkg::EXC_RESET,
            exc_classifier_pkg::EXC_MCHECK: c = '{1'b1, 1'b0, 1'b0};
            exc_classifier_pkg::EXC_EXT:    c = '{1'b1, 1'b1, 1'b1};
            default:                        c = '{1'b0, 1'b1, 1'b0};
        endcase
        return c;
    endfunction : class_of

    logic [4:0] pin_s;

    exc_sync2 #(.WIDTH(5)) u_pins (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .D      ({SOFT_RESET_IN, HARD_RESET_IN, TRANSFER_ERROR_ACK,
                  MACHINE_CHECK_IN, EXT_IRQ_IN}),
        .Q      (pin_s)
    );

    logic soft_rst_s, hard_rst_s, tea_s, mcp_s, eirq_s;
    assign {soft_rst_s, hard_rst_s, tea_s, mcp_s, eirq_s} = pin_s;

    logic [31:0]                   dfc_r;
    logic [31:0]                   sms_r;
    logic [2:0]                    ctl_r;
    logic [31:0]                   vbase_r;
    logic [7:0]                    class_r;
    logic [`EV_W-1:0]              stat_r;
    logic [`EV_W-1:0]              mask_r;
    logic                          rst_prev_r, tea_prev_r, mcp_prev_r;
    logic                          rst_pend_r, mc_pend_r, dfl_pend_r, ifl_pend_r;
    logic                          sync_pend_r, sync_fp_r, sync_fpimp_r;
    logic [`VEC_W-1:0]             sync_off_r;
    logic                          wr_pend_r, rd_pend_r, sz_ok_r;
    logic [`REG_AW-1:0]            addr_r;
    logic [2:0]                    ctl_sw;
    logic                          ctl_nxt_pr;

    logic rst_lvl, rst_rise, tea_lvl, mc_rise;
    assign rst_lvl  = soft_rst_s | hard_rst_s;
    assign rst_rise = rst_lvl & ~rst_prev_r;
    assign tea_lvl  = tea_s & DATA_BUS_ACTIVE;
    assign mc_rise  = (tea_lvl & ~tea_prev_r) | (mcp_s & ~mcp_prev_r)
                    | ADDR_PARITY_ERR | DATA_PARITY_ERR;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_prev_r <= 1'b0;
            tea_prev_r <= 1'b0;
            mcp_prev_r <= 1'b0;
        end else begin
            rst_prev_r <= rst_lvl;
            tea_prev_r <= tea_lvl;
            mcp_prev_r <= mcp_s;
        end
    end

    // data access cause decode
    logic        d_miss, d_dstore, d_ear_off, d_fault;
    logic [31:0] dfc_nxt;
    assign d_miss    = DACC_MISS_PRI & DACC_MISS_SEC & DACC_MISS_BLK;
    assign d_dstore  = (DACC_EXT_CTRL & DACC_WRITE_THRU) | DACC_DIRECT_STORE;
    assign d_ear_off = DACC_EXT_CTRL & ~ctl_r[`CTL_EAE];
    assign d_fault   = DACC_CHECK & (d_miss | DACC_PROT_DENY | d_dstore | d_ear_off);

    always_comb begin
        dfc_nxt                  = '0;
        dfc_nxt[31-`DFC_MISS]    = d_miss;
        dfc_nxt[31-`DFC_PROT]    = DACC_PROT_DENY;
        dfc_nxt[31-`DFC_DSTORE]  = d_dstore;
        dfc_nxt[31-`DFC_STORE]   = DACC_STORE;
        dfc_nxt[31-`DFC_EAR_OFF] = d_ear_off;
    end

    // instruction fetch decode
    logic i_deny, i_fault;
    assign i_deny  = read_forbidden(IFETCH_SUPERVISOR_KEY, IFETCH_USER_KEY,
                                    ctl_r[`CTL_PR], IFETCH_PAGE_PROTECT);
    assign i_fault = IFETCH_CHECK
                   & (IFETCH_PAGE_FAULT | IFETCH_DIRECT_STORE | i_deny);

    exc_classifier_pkg::exc_kind_t  sel;
    exc_classifier_pkg::exc_class_t sel_cls;
    logic                           ext_ready;

    // maskable irq waits for an instruction boundary so the saved state is exact
    assign ext_ready = eirq_s & ctl_r[`CTL_EE]
                     & (INSTR_COMPLETE | (~INSTR_IN_FLIGHT & RESTART_KNOWN));

    // fixed order: catastrophic first, instruction faults before the irq
    always_comb begin
        if (rst_pend_r) begin
            sel = exc_classifier_pkg::EXC_RESET;
        end else if (mc_pend_r) begin
            sel = exc_classifier_pkg::EXC_MCHECK;
        end else if (dfl_pend_r) begin
            sel = exc_classifier_pkg::EXC_DFAULT;
        end else if (ifl_pend_r) begin
            sel = exc_classifier_pkg::EXC_IFAULT;
        end else if (sync_pend_r) begin
            sel = exc_classifier_pkg::EXC_SYNC;
        end else if (ext_ready) begin
            sel = exc_classifier_pkg::EXC_EXT;
        end else begin
            sel = exc_classifier_pkg::EXC_NONE;
        end
    end

    assign sel_cls = class_of(sel);

    logic take;
    assign take = (sel != exc_classifier_pkg::EXC_NONE);

    // a new event beats the clear of its own pending flag
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_pend_r  <= 1'b0;
            mc_pend_r   <= 1'b0;
            dfl_pend_r  <= 1'b0;
            ifl_pend_r  <= 1'b0;
            sync_pend_r <= 1'b0;
        end else begin
            rst_pend_r  <= rst_rise | (rst_pend_r & (sel != exc_classifier_pkg::EXC_RESET));
            mc_pend_r   <= mc_rise | (mc_pend_r & (sel != exc_classifier_pkg::EXC_MCHECK));
            dfl_pend_r  <= d_fault | (dfl_pend_r & (sel != exc_classifier_pkg::EXC_DFAULT));
            ifl_pend_r  <= i_fault | (ifl_pend_r & (sel != exc_classifier_pkg::EXC_IFAULT));
            sync_pend_r <= SYNC_EXC_REQ | (sync_pend_r & (sel != exc_classifier_pkg::EXC_SYNC));
        end
    end

    // the fp mode bit is recorded only; delivery is always precise
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync_off_r   <= `VEC_RESERVED;
            sync_fp_r    <= 1'b0;
            sync_fpimp_r <= 1'b0;
        end else if (SYNC_EXC_REQ) begin
            sync_off_r   <= SYNC_EXC_OFFSET;
            sync_fp_r    <= SYNC_EXC_FP;
            sync_fpimp_r <= SYNC_EXC_FP & FP_IMPRECISE_MODE;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EXC_TAKEN      <= 1'b0;
            EXC_OFFSET     <= `VEC_RESERVED;
            EXC_ENTRY_ADDR <= `VBASE_RST;
            EXC_ASYNC      <= 1'b0;
            EXC_PRECISE    <= 1'b0;
            EXC_MASKABLE   <= 1'b0;
        end else begin
            EXC_TAKEN <= take;
            if (take) begin
                EXC_OFFSET     <= vec_of(sel, sync_off_r);
                EXC_ENTRY_ADDR <= {vbase_r[31:`VEC_W], vec_of(sel, sync_off_r)};
                EXC_ASYNC      <= sel_cls.async;
                EXC_PRECISE    <= sel_cls.precise;
                EXC_MASKABLE   <= sel_cls.maskable;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            class_r <= 8'h00;
        end else if (take) begin
            class_r <= {1'b0, sel == exc_classifier_pkg::EXC_SYNC && sync_fpimp_r,
                        sel == exc_classifier_pkg::EXC_SYNC && sync_fp_r,
                        sel, sel_cls.maskable, sel_cls.precise} ;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FETCH_REFUSED <= 1'b0;
            SUPERVISOR    <= 1'b1;
        end else begin
            FETCH_REFUSED <= IFETCH_CHECK & i_deny;
            SUPERVISOR    <= ~ctl_nxt_pr;
        end
    end

    logic take_ap;
    assign take_ap = HSEL & HTRANS[1] & HREADY;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            sz_ok_r   <= 1'b0;
            addr_r    <= '0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            wr_pend_r <= take_ap & HWRITE;
            rd_pend_r <= take_ap & ~HWRITE;
            if (take_ap) begin
                addr_r  <= HADDR[`REG_AW-1:0];
                sz_ok_r <= (HSIZE == 3'h2) && (HADDR[1:0] == 2'h0);
            end
            // reads get one wait because HRDATA is registered at the end of the first data-phase cycle
            HREADYOUT <= ~(take_ap & ~HWRITE);
        end
    end

    logic wr_ok;
    assign wr_ok = wr_pend_r & sz_ok_r;

    logic [31:0] rdata_c;
    always_comb begin
        unique case (addr_r)
            `REG_DFC:   rdata_c = dfc_r;
            `REG_SMS:   rdata_c = sms_r;
            `REG_CTL:   rdata_c = {29'h0, ctl_r};
            `REG_VBASE: rdata_c = vbase_r;
            `REG_ENTRY: rdata_c = EXC_ENTRY_ADDR;
            `REG_CLASS: rdata_c = {24'h0, class_r};
            `REG_STAT:  rdata_c = {26'h0, stat_r};
            `REG_MASK:  rdata_c = {26'h0, mask_r};
            default:    rdata_c = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            HRDATA <= rdata_c;
        end
    end

    // hardware capture wins over a software write in the same cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dfc_r <= `DFC_RST;
        end else if (d_fault) begin
            dfc_r <= dfc_nxt;
        end else if (wr_ok && addr_r == `REG_DFC) begin
            dfc_r <= HWDATA;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sms_r <= `SMS_RST;
        end else if (i_fault) begin
            sms_r                  <= 32'h0000_0000;
            sms_r[31-`SMS_DSTORE]  <= IFETCH_DIRECT_STORE;
            sms_r[31-`SMS_PROT]    <= i_deny;
        end else if (wr_ok && addr_r == `REG_SMS) begin
            sms_r <= HWDATA;
        end
    end

    // taking an exception enters supervisor state with the irq enable off
    assign ctl_sw     = (wr_ok && addr_r == `REG_CTL) ? HWDATA[2:0] : ctl_r;
    assign ctl_nxt_pr = take ? 1'b0 : ctl_sw[`CTL_PR];

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctl_r <= `CTL_RST;
        end else begin
            ctl_r[`CTL_EAE] <= ctl_sw[`CTL_EAE];
            ctl_r[`CTL_EE]  <= ctl_sw[`CTL_EE] & ~take;
            ctl_r[`CTL_PR]  <= ctl_nxt_pr;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            vbase_r <= `VBASE_RST;
            mask_r  <= `MASK_RST;
        end else if (wr_ok) begin
            if (addr_r == `REG_VBASE) begin
                vbase_r <= {HWDATA[31:`VEC_W], `VEC_RESERVED};
            end
            if (addr_r == `REG_MASK) begin
                mask_r <= HWDATA[`EV_W-1:0];
            end
        end
    end

    // status bit n follows kind code n+1
    logic [`EV_W-1:0] ev, stat_nxt;
    assign ev = take ? `EV_W'(1) << (sel - 3'h1) : '0;

    // read clears, but an event in the same cycle survives
    assign stat_nxt = ((rd_pend_r && addr_r == `REG_STAT) ? '0 : stat_r) | ev;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_r <= '0;
            IRQ    <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            IRQ    <= |(stat_nxt & mask_r);
        end
    end

endmodule : cpu_exception_classifier

`default_nettype wire

// ==== exc_classifier_consts.svh ====
`ifndef EXC_CLASSIFIER_CONSTS_SVH
`define EXC_CLASSIFIER_CONSTS_SVH

// exception vector offsets
`define VEC_W          20
`define VEC_RESERVED   20'h00000
`define VEC_SYS_RESET  20'h00100
`define VEC_MCHECK     20'h00200
`define VEC_DFAULT     20'h00300
`define VEC_IFAULT     20'h00400
`define VEC_EXT_IRQ    20'h00500

// register byte offsets on the bus
`define REG_AW         8
`define REG_DFC        8'h00
`define REG_SMS        8'h04
`define REG_CTL        8'h08
`define REG_VBASE      8'h0C
`define REG_ENTRY      8'h10
`define REG_CLASS      8'h14
`define REG_STAT       8'h18
`define REG_MASK       8'h1C

// fault cause bits, numbered from the msb as bit 0
`define DFC_MISS       1
`define DFC_PROT       4
`define DFC_DSTORE     5
`define DFC_STORE      6
`define DFC_EAR_OFF    11
`define SMS_DSTORE     3
`define SMS_PROT       4

// control register fields
`define CTL_EE         0
`define CTL_EAE        1
`define CTL_PR         2

// event bits of status and mask
`define EV_W           6
`define EV_RESET       0
`define EV_MCHECK      1
`define EV_DFAULT      2
`define EV_IFAULT      3
`define EV_EXT         4
`define EV_SYNC        5

// reset values
`define CTL_RST        3'h0
`define VBASE_RST      32'h0000_0000
`define MASK_RST       6'h00
`define DFC_RST        32'h0000_0000
`define SMS_RST        32'h0000_0000

`endif

// ==== exc_classifier_pkg.sv ====
package exc_classifier_pkg;

    typedef enum logic [2:0] {
        EXC_NONE   = 3'h0,
        EXC_RESET  = 3'h1,
        EXC_MCHECK = 3'h2,
        EXC_DFAULT = 3'h3,
        EXC_IFAULT = 3'h4,
        EXC_EXT    = 3'h5,
        EXC_SYNC   = 3'h6
    } exc_kind_t;

    typedef struct packed {
        logic async;
        logic precise;
        logic maskable;
    } exc_class_t;

endpackage : exc_classifier_pkg

// ==== exc_classifier_properties.sv ====
`include "exc_classifier_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module exc_classifier_properties (
    input wire logic              CLK,
    input wire logic              ARST_N,
    input wire logic              SOFT_RESET_IN,
    input wire logic              HARD_RESET_IN,
    input wire logic              ADDR_PARITY_ERR,
    input wire logic              DATA_PARITY_ERR,
    input wire logic              IFETCH_CHECK,
    input wire logic              IFETCH_SUPERVISOR_KEY,
    input wire logic              IFETCH_USER_KEY,
    input wire logic [1:0]        IFETCH_PAGE_PROTECT,
    input wire logic              EXC_TAKEN,
    input wire logic [`VEC_W-1:0] EXC_OFFSET,
    input wire logic [31:0]       EXC_ENTRY_ADDR,
    input wire logic              EXC_ASYNC,
    input wire logic              EXC_PRECISE,
    input wire logic              EXC_MASKABLE,
    input wire logic              SUPERVISOR,
    input wire logic              FETCH_REFUSED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_take(logic [`VEC_W-1:0] off);
        EXC_TAKEN && EXC_OFFSET == off;
    endsequence
    a_vector_used: assert property (EXC_TAKEN |-> EXC_OFFSET != `VEC_RESERVED)
        else $error("reserved vector taken");
    a_reset_vector: assert property (
        $rose(SOFT_RESET_IN || HARD_RESET_IN) |-> ##[1:8] s_take(`VEC_SYS_RESET))
        else $error("reset pin not taken");
    a_check_vector: assert property (
        (ADDR_PARITY_ERR || DATA_PARITY_ERR) && !SOFT_RESET_IN && !HARD_RESET_IN
        |-> ##[1:4] s_take(`VEC_MCHECK))
        else $error("parity error not taken");
    a_async_class: assert property (
        EXC_TAKEN && EXC_OFFSET inside {`VEC_SYS_RESET, `VEC_MCHECK}
        |-> EXC_ASYNC && !EXC_PRECISE && !EXC_MASKABLE)
        else $error("bad nonmaskable class");
    a_ext_class: assert property (
        s_take(`VEC_EXT_IRQ) |-> EXC_ASYNC && EXC_PRECISE && EXC_MASKABLE)
        else $error("bad maskable class");
    a_sync_precise: assert property (
        EXC_TAKEN && !EXC_ASYNC |-> EXC_PRECISE && !EXC_MASKABLE)
        else $error("sync exception not precise");
    a_entry_formed: assert property (
        EXC_TAKEN |-> EXC_ENTRY_ADDR[`VEC_W-1:0] == EXC_OFFSET && SUPERVISOR)
        else $error("bad entry address or state");
    a_fetch_denied: assert property (
        IFETCH_CHECK && (SUPERVISOR ? IFETCH_SUPERVISOR_KEY : IFETCH_USER_KEY)
        && IFETCH_PAGE_PROTECT == 2'b00 |=> FETCH_REFUSED)
        else $error("forbidden fetch not refused");
    a_refuse_cause: assert property (FETCH_REFUSED |-> $past(IFETCH_CHECK))
        else $error("refusal without fetch");
endmodule : exc_classifier_properties
bind cpu_exception_classifier exc_classifier_properties exc_classifier_properties_i (.*);
`default_nettype wire

// ==== exc_event_sources.sv ====
`timescale 1ns/1ps
`default_nettype none
module exc_event_sources (
    input  wire logic       CLK,
    input  wire logic       src_go,
    input  wire logic [2:0] src_sel,
    output var  logic       SOFT_RESET_IN,
    output var  logic       HARD_RESET_IN,
    output var  logic       MACHINE_CHECK_IN,
    output var  logic       TRANSFER_ERROR_ACK,
    output var  logic       DATA_BUS_ACTIVE,
    output var  logic       EXT_IRQ_IN
);
    logic [3:0] hold_r = '0;
    logic [2:0] sel_r  = '0;
    logic       act;
    // levels stay up long enough for the two-stage pin synchronizers
    always_ff @(posedge CLK) begin
        if (src_go) begin
            hold_r <= 4'h8;
            sel_r  <= src_sel;
        end else if (act) begin
            hold_r <= hold_r - 4'h1;
        end
    end
    assign act                = hold_r != 4'h0;
    assign SOFT_RESET_IN      = act && sel_r == 3'h0;
    assign HARD_RESET_IN      = act && sel_r == 3'h1;
    assign MACHINE_CHECK_IN   = act && sel_r == 3'h2;
    // error ack sits well inside the bus window so it is seen during a transfer
    assign DATA_BUS_ACTIVE    = act && sel_r == 3'h3;
    assign TRANSFER_ERROR_ACK = hold_r > 4'h4 && sel_r == 3'h3;
    assign EXT_IRQ_IN         = act && sel_r == 3'h4;
endmodule : exc_event_sources
`default_nettype wire

// ==== exc_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

module exc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             CLK,
    input  wire logic             ARST_N,
    input  wire logic [WIDTH-1:0] D,
    output var  logic [WIDTH-1:0] Q
);

    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            meta_r <= '0;
            Q      <= '0;
        end else begin
            meta_r <= D;
            Q      <= meta_r;
        end
    end

endmodule : exc_sync2

`default_nettype wire

// ==== tb_cpu_exception_classifier.sv ====
`include "exc_classifier_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_exception_classifier;
    logic        CLK = '0, ARST_N = '0, HSEL = '0, HWRITE = '0, src_go = '0;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, EXC_ENTRY_ADDR, q;
    logic [19:0] SYNC_EXC_OFFSET = 20'h00700, EXC_OFFSET;
    logic [2:0]  HSIZE = 3'h2, src_sel = '0;
    logic [1:0]  HTRANS = '0, IFETCH_PAGE_PROTECT = '0;
    logic        ADDR_PARITY_ERR = '0, DATA_PARITY_ERR = '0, DACC_CHECK = '0;
    logic        DACC_MISS_PRI = '0, DACC_MISS_SEC = '0, DACC_MISS_BLK = '0;
    logic        DACC_PROT_DENY = '0, DACC_EXT_CTRL = '0, DACC_WRITE_THRU = '0;
    logic        DACC_DIRECT_STORE = '0, DACC_STORE = '0, IFETCH_CHECK = '0;
    logic        IFETCH_PAGE_FAULT = '0, IFETCH_DIRECT_STORE = '0, SYNC_EXC_REQ = '0;
    logic        IFETCH_SUPERVISOR_KEY = '0, IFETCH_USER_KEY = '0, SYNC_EXC_FP = '0;
    logic        FP_IMPRECISE_MODE = '0, INSTR_COMPLETE = '0, INSTR_IN_FLIGHT = '1;
    logic        RESTART_KNOWN = '0, HREADYOUT, HRESP, SOFT_RESET_IN, HARD_RESET_IN;
    logic        TRANSFER_ERROR_ACK, MACHINE_CHECK_IN, EXT_IRQ_IN, DATA_BUS_ACTIVE;
    logic        EXC_TAKEN, EXC_ASYNC, EXC_PRECISE, EXC_MASKABLE, SUPERVISOR;
    logic        FETCH_REFUSED, IRQ;
    wire         HREADY = HREADYOUT;
    int          bad_count = 0, samples_checked = 0, takes = 0, t0;
    cpu_exception_classifier cpu_exception_classifier_i (.*);
    exc_event_sources exc_event_sources_i (.*);
    always #2.5 CLK = ~CLK;
    always @(posedge CLK) if (EXC_TAKEN === 1'b1) takes++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge CLK); while (HREADY !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADY !== 1'b1);
        q = HRDATA;
        check({31'h0, HRESP}, 32'h0);
    endtask : bus
    task automatic take(input logic [19:0] off, input logic [2:0] cls);
        do @(posedge CLK); while (EXC_TAKEN !== 1'b1);
        check({12'h0, EXC_OFFSET}, {12'h0, off});
        check({29'h0, EXC_ASYNC, EXC_PRECISE, EXC_MASKABLE}, {29'h0, cls});
        check(EXC_ENTRY_ADDR, {12'hABC, off});
        repeat (10) @(posedge CLK);
    endtask : take
    task automatic raise(input logic [2:0] s);
        src_sel <= s;
        src_go <= 1'b1;
        @(posedge CLK);
        src_go <= 1'b0;
    endtask : raise
    task automatic access(input logic inst, input logic [7:0] f, input logic [31:0] exp);
        {DACC_STORE, DACC_DIRECT_STORE, DACC_WRITE_THRU, DACC_EXT_CTRL, DACC_PROT_DENY,
         DACC_MISS_BLK, DACC_MISS_SEC, DACC_MISS_PRI} <= f;
        {IFETCH_PAGE_PROTECT, IFETCH_USER_KEY, IFETCH_SUPERVISOR_KEY, IFETCH_DIRECT_STORE,
         IFETCH_PAGE_FAULT} <= f[5:0];
        IFETCH_CHECK <= inst;
        DACC_CHECK <= !inst;
        @(posedge CLK);
        IFETCH_CHECK <= 1'b0;
        DACC_CHECK <= 1'b0;
        @(posedge CLK);
        if (inst) check({31'h0, FETCH_REFUSED}, {31'h0, f[5:2] == 4'h1});
        take(inst ? `VEC_IFAULT : `VEC_DFAULT, 3'b010);
        bus(1'b0, inst ? `REG_SMS : `REG_DFC, 32'h0);
        check(q, exp);
    endtask : access
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (4) @(posedge CLK);
        ARST_N <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            check(q, 32'h0);
        end
        bus(1'b1, `REG_VBASE, 32'hABCDE123);
        bus(1'b0, `REG_VBASE, 32'h0);
        check(q, 32'hABC00000);
        bus(1'b1, `REG_MASK, 32'h3F);
        $display("registers done");
        for (int i = 0; i < 4; i++) begin
            raise(3'(i));
            take(i < 2 ? `VEC_SYS_RESET : `VEC_MCHECK, 3'b100);
        end
        for (int j = 0; j < 2; j++) begin
            {ADDR_PARITY_ERR, DATA_PARITY_ERR} <= 2'(j + 1);
            @(posedge CLK);
            {ADDR_PARITY_ERR, DATA_PARITY_ERR} <= 2'h0;
            take(`VEC_MCHECK, 3'b100);
        end
        $display("async done");
        access(1'b0, 8'h87, 32'h42000000);
        access(1'b0, 8'h0B, 32'h08000000);
        access(1'b0, 8'h30, 32'h04100000);
        access(1'b0, 8'h40, 32'h04000000);
        access(1'b1, 8'h01, 32'h0);
        access(1'b1, 8'h02, 32'h10000000);
        access(1'b1, 8'h04, 32'h08000000);
        $display("storage faults done");
        FP_IMPRECISE_MODE <= 1'b1;
        SYNC_EXC_FP <= 1'b1;
        SYNC_EXC_REQ <= 1'b1;
        @(posedge CLK);
        SYNC_EXC_REQ <= 1'b0;
        take(20'h00700, 3'b010);
        bus(1'b0, `REG_CLASS, 32'h0);
        check(q, 32'h79);
        t0 = takes;
        raise(3'h4);
        repeat (12) @(posedge CLK);
        check(32'(takes), 32'(t0));
        bus(1'b1, `REG_CTL, 32'h1);
        raise(3'h4);
        repeat (5) @(posedge CLK);
        check(32'(takes), 32'(t0));
        INSTR_COMPLETE <= 1'b1;
        @(posedge CLK);
        INSTR_COMPLETE <= 1'b0;
        take(`VEC_EXT_IRQ, 3'b111);
        $display("sync and external done");
        check({31'h0, IRQ}, 32'h1);
        bus(1'b0, `REG_STAT, 32'h0);
        check(q, 32'h3F);
        repeat (2) @(posedge CLK);
        check({31'h0, IRQ}, 32'h0);
        bus(1'b1, `REG_MASK, 32'h0);
        raise(3'h2);
        take(`VEC_MCHECK, 3'b100);
        check({31'h0, IRQ}, 32'h0);
        bus(1'b0, `REG_STAT, 32'h0);
        check(q, 32'h2);
        $display("interrupt done");
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge CLK);
        bad_count++;
        complete_run();
    end
endmodule : tb_cpu_exception_classifier
`default_nettype wire
